// ===== hdl/opm_pkg.sv
package opm_pkg;
  // clock rate and derived cycle counts
  localparam int CLK_HZ = 10000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int ACT_MIN_US = 210;
  localparam int ACT_MAX_US = 400;
  localparam int STBY_MAX_US = 300;
  localparam int PWRUP_MAX_US = 30;
  localparam int FILT_MIN_US = 10;
  localparam int FILT_MAX_US = 100;
  localparam int FREQ_LO_HZ = 170;
  localparam int FREQ_HI_HZ = 225;
  // standby-to-active delay: midpoint of the window, rounded up to cycles
  localparam int ACT_DLY_CYC = ((ACT_MIN_US + ACT_MAX_US) / 2 * 1000 + CLK_NS - 1) / CLK_NS;
  // active-to-standby done in one cycle, well inside the limit
  localparam int STBY_DLY_CYC = 1;
  localparam int PWRUP_DLY_CYC = (PWRUP_MAX_US * 1000 / CLK_NS) / 2;
  localparam int FILT_CYC = ((FILT_MIN_US + FILT_MAX_US) / 2 * 1000 + CLK_NS - 1) / CLK_NS;
  // prescaler ticks per PWM step: period / 1024 steps
  localparam int PRE_LO_CYC = CLK_HZ / (FREQ_LO_HZ * 1024);
  localparam int PRE_HI_CYC = CLK_HZ / (FREQ_HI_HZ * 1024);
  localparam int NUM_OUT = 9;
  localparam int NUM_LAMP = 4;
  localparam int DUTY_W = 10;
  localparam int CNT_W = 16;
  localparam logic RST_SRC_SEL = 1'b0;
  localparam logic RST_MODE = 1'b0;

  typedef enum logic [3:0] {
    OPM_UNPWR = 4'h1,
    OPM_STBY = 4'h2,
    OPM_WAKE = 4'h4,
    OPM_ACT = 4'h8
  } opm_mode_t;
endpackage

// ===== hdl/opm_lamp_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module opm_lamp_pwm (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic run_i, // oscillator running
  input wire logic freq_sel_i, // 0 low, 1 high frequency
  input wire logic res_sel_i, // 0 seven-bit, 1 ten-bit
  input wire logic [9:0] duty_i, // duty value
  output logic pwm_o // generated waveform
);
  logic [15:0] pre_ff;
  logic [9:0] per_ff;
  logic [15:0] pre_lim;
  logic step;
  logic [9:0] cmp_duty;

  assign pre_lim = freq_sel_i ? 16'(opm_pkg::PRE_HI_CYC - 1) : 16'(opm_pkg::PRE_LO_CYC - 1);
  assign step = run_i && (pre_ff >= pre_lim);

  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      pre_ff <= 16'h0000;
    end else if (step) begin
      pre_ff <= 16'h0000;
    end else begin
      pre_ff <= pre_ff + 16'h0001;
    end
  end

  // free-running period counter
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      per_ff <= 10'h000;
    end else if (step) begin
      per_ff <= per_ff + 10'h001; // RULE25
    end
  end

  // seven-bit duty scaled up to the ten-bit counter
  assign cmp_duty = res_sel_i ? duty_i : {duty_i[6:0], 3'h0}; // RULE17 RULE18

  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= (per_ff < cmp_duty); // RULE25
    end
  end

  chk_pwm_off_zero: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE25
    (run_i && cmp_duty == 10'h000) |=> !pwm_o) else $error("pwm high at zero duty");
endmodule
`default_nettype wire

// ===== hdl/opm_ctrl.sv
// Function
// [RULE1] outputs enable 210..400 us after chip select rises with mode active
// [RULE2] outputs disable within 300 us after chip select rises with mode standby
// [RULE3] serial ready within 30 us of logic supply good, entering standby
// [RULE4] thermal warning and shutdown filtered 10..100 us before status update
// [RULE5] frequency select zero gives 170 Hz, one gives 225 Hz
// [RULE6] power supply undervoltage tristates outputs and sets combined fault bit
// [RULE7] combined fault bit set by overcurrent, overvoltage or undervoltage
// [RULE8] undervoltage also sets dedicated undervoltage flag
// [RULE9] recovery bit zero: outputs return automatically when supply normal
// [RULE10] recovery bit one: outputs stay off until host clears status
// [RULE11] host should set recovery bit to avoid short-circuit oscillation
// [RULE12] standby keeps charge pump off; active starts oscillator and pump
// [RULE13] each output combines serial on/off with its assigned PWM input
// [RULE14] PWM acts only when output's PWM enable bit is set
// [RULE15] lamp two and four use pin b; all others use pin a
// [RULE16] source select resets to external; one picks internal generator
// [RULE17] internal lamps use 7-bit or 10-bit duty per resolution bit
// [RULE18] each lamp has own duty value and frequency select
// [RULE19] host must make shared sense pin valid when used as PWM
// [RULE20] open serial inputs idle low, open chip select idles high
// [RULE21] register contents kept when power supply is lost
// [RULE22] logic values unchanged while logic supply is marginal
// [RULE23] output conducts only when enabled and selected PWM is high
// [RULE24] external PWM pins synchronised before gating outputs
// [RULE25] lamp high while period counter below scaled duty
`timescale 1ns/100ps
`default_nettype none
module opm_ctrl (
  input wire logic clk_i, // system clock, 10 MHz
  input wire logic nrst_i, // sync reset, active low
  input wire logic logic_supply_ok_i, // logic supply above release threshold
  input wire logic csb_i, // serial chip select pin, active low
  input wire logic mode_active_i, // operating-mode bit as written
  input wire logic [8:0] out_on_i, // serial on/off per output
  input wire logic [8:0] output_pwm_enable_i, // per-output PWM enable
  input wire logic pwm_source_select_i, // 0 external, 1 internal
  input wire logic pwm_resolution_select_i, // 0 seven-bit, 1 ten-bit
  input wire logic [3:0] pwm_freq_select_i, // per lamp frequency select
  input wire logic [39:0] pwm_duty_value_i, // four lamps of ten bits
  input wire logic supply_fault_recovery_bit_i, // disable auto-recovery
  input wire logic status_clear_i, // host clears supply status, pulse
  input wire logic pwm_pin_a_i, // external PWM pin a
  input wire logic sense_or_pwm_pin_b_i, // external PWM pin b
  input wire logic overcurrent_i, // overcurrent event
  input wire logic ps_overvolt_i, // power supply overvoltage
  input wire logic ps_undervolt_i, // power supply undervoltage
  input wire logic thermal_warn_raw_i, // raw thermal warning
  input wire logic thermal_sd_raw_i, // raw thermal shutdown
  output logic serial_ready_o, // serial interface accepts frames
  output logic charge_pump_output_o, // charge pump and oscillator run
  output logic drivers_en_o, // output drivers enabled
  output logic [8:0] out_drive_o, // per-output conduct command
  output logic [8:0] out_hiz_o, // per-output high impedance
  output logic combined_fault_status_bit_o, // combined supply/overcurrent bit
  output logic power_supply_undervolt_flag_o, // dedicated undervoltage flag
  output logic thermal_warning_flag_o, // filtered thermal warning
  output logic thermal_shutdown_flag_o // filtered thermal shutdown
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] csb_sy_ff, pa_sy_ff, pb_sy_ff, lsok_sy_ff;
  logic csb_q_ff, pa_q_ff, pb_q_ff, lsok_q_ff;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      csb_sy_ff <= 3'h7; // RULE20
      pa_sy_ff <= 3'h0;
      pb_sy_ff <= 3'h0;
      lsok_sy_ff <= 3'h0;
    end else begin
      csb_sy_ff <= {csb_sy_ff[1:0], csb_i};
      pa_sy_ff <= {pa_sy_ff[1:0], pwm_pin_a_i}; // RULE24
      pb_sy_ff <= {pb_sy_ff[1:0], sense_or_pwm_pin_b_i}; // RULE24
      lsok_sy_ff <= {lsok_sy_ff[1:0], logic_supply_ok_i};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      csb_q_ff <= 1'b1;
      pa_q_ff <= 1'b0;
      pb_q_ff <= 1'b0;
      lsok_q_ff <= 1'b0;
    end else begin
      if (csb_sy_ff[1] == csb_sy_ff[2]) csb_q_ff <= csb_sy_ff[2];
      if (pa_sy_ff[1] == pa_sy_ff[2]) pa_q_ff <= pa_sy_ff[2];
      if (pb_sy_ff[1] == pb_sy_ff[2]) pb_q_ff <= pb_sy_ff[2];
      if (lsok_sy_ff[1] == lsok_sy_ff[2]) lsok_q_ff <= lsok_sy_ff[2];
    end
  end

  logic csb_prev_ff;
  logic csb_rise;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      csb_prev_ff <= 1'b1;
    end else begin
      csb_prev_ff <= csb_q_ff;
    end
  end
  assign csb_rise = csb_q_ff && !csb_prev_ff;

  // ----------------------------------------------------------------
  // operating mode sequencer
  // ----------------------------------------------------------------
  opm_pkg::opm_mode_t mode_ff, nxt_mode;
  logic [15:0] dly_ff;

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      opm_pkg::OPM_UNPWR: begin
        if (lsok_q_ff && dly_ff >= 16'(opm_pkg::PWRUP_DLY_CYC - 1)) nxt_mode = opm_pkg::OPM_STBY; // RULE3
      end
      opm_pkg::OPM_STBY: begin
        if (csb_rise && mode_active_i) nxt_mode = opm_pkg::OPM_WAKE; // RULE12
      end
      opm_pkg::OPM_WAKE: begin
        if (csb_rise && !mode_active_i) nxt_mode = opm_pkg::OPM_STBY;
        else if (dly_ff >= 16'(opm_pkg::ACT_DLY_CYC - 1)) nxt_mode = opm_pkg::OPM_ACT; // RULE1
      end
      opm_pkg::OPM_ACT: begin
        if (csb_rise && !mode_active_i) nxt_mode = opm_pkg::OPM_STBY; // RULE2
      end
      default: nxt_mode = opm_pkg::OPM_UNPWR;
    endcase
    // marginal logic supply holds unpowered and never drops a powered mode back to it
    if (!lsok_q_ff && mode_ff == opm_pkg::OPM_UNPWR) nxt_mode = opm_pkg::OPM_UNPWR; // RULE22
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_ff <= opm_pkg::OPM_UNPWR;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || nxt_mode != mode_ff) begin
      dly_ff <= 16'h0000;
    end else if ((mode_ff == opm_pkg::OPM_UNPWR && lsok_q_ff) || mode_ff == opm_pkg::OPM_WAKE) begin
      dly_ff <= dly_ff + 16'h0001;
    end else begin
      dly_ff <= 16'h0000;
    end
  end

  assign serial_ready_o = (mode_ff != opm_pkg::OPM_UNPWR); // RULE3
  assign charge_pump_output_o = (mode_ff == opm_pkg::OPM_WAKE) || (mode_ff == opm_pkg::OPM_ACT); // RULE12
  assign drivers_en_o = (mode_ff == opm_pkg::OPM_ACT); // RULE1 RULE2

  // ----------------------------------------------------------------
  // supply fault handling
  // ----------------------------------------------------------------
  logic uv_flag_ff, comb_flag_ff, fault_lock_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      uv_flag_ff <= 1'b0;
      comb_flag_ff <= 1'b0;
    end else begin
      // set wins over clear
      uv_flag_ff <= ps_undervolt_i || (uv_flag_ff && !status_clear_i); // RULE8 RULE21
      comb_flag_ff <= overcurrent_i || ps_overvolt_i || ps_undervolt_i
                      || (comb_flag_ff && !status_clear_i); // RULE6 RULE7
    end
  end
  assign power_supply_undervolt_flag_o = uv_flag_ff;
  assign combined_fault_status_bit_o = comb_flag_ff;

  // latched lockout only when auto-recovery is disabled
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fault_lock_ff <= 1'b0;
    end else if ((ps_undervolt_i || ps_overvolt_i) && supply_fault_recovery_bit_i) begin
      fault_lock_ff <= 1'b1; // RULE10
    end else if (status_clear_i || !supply_fault_recovery_bit_i) begin
      fault_lock_ff <= 1'b0; // RULE9
    end
  end

  logic supply_block;
  assign supply_block = ps_undervolt_i || ps_overvolt_i || fault_lock_ff; // RULE6 RULE9 RULE10

  // ----------------------------------------------------------------
  // thermal filters
  // ----------------------------------------------------------------
  logic [15:0] tw_cnt_ff, tsd_cnt_ff;
  logic tw_ff, tsd_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tw_cnt_ff <= 16'h0000;
      tw_ff <= 1'b0;
    end else if (thermal_warn_raw_i == tw_ff) begin
      tw_cnt_ff <= 16'h0000;
    end else if (tw_cnt_ff >= 16'(opm_pkg::FILT_CYC - 1)) begin
      tw_cnt_ff <= 16'h0000;
      tw_ff <= thermal_warn_raw_i; // RULE4
    end else begin
      tw_cnt_ff <= tw_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tsd_cnt_ff <= 16'h0000;
      tsd_ff <= 1'b0;
    end else if (thermal_sd_raw_i == tsd_ff) begin
      tsd_cnt_ff <= 16'h0000;
    end else if (tsd_cnt_ff >= 16'(opm_pkg::FILT_CYC - 1)) begin
      tsd_cnt_ff <= 16'h0000;
      tsd_ff <= thermal_sd_raw_i; // RULE4
    end else begin
      tsd_cnt_ff <= tsd_cnt_ff + 16'h0001;
    end
  end
  assign thermal_warning_flag_o = tw_ff;
  assign thermal_shutdown_flag_o = tsd_ff;

  // ----------------------------------------------------------------
  // PWM sources and output combination
  // ----------------------------------------------------------------
  logic [3:0] lamp_pwm;
  genvar g;
  generate
    for (g = 0; g < opm_pkg::NUM_LAMP; g++) begin : g_lamp
      opm_lamp_pwm u_pwm (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .run_i(charge_pump_output_o),
        .freq_sel_i(pwm_freq_select_i[g]), // RULE5 RULE18
        .res_sel_i(pwm_resolution_select_i),
        .duty_i(pwm_duty_value_i[g*10 +: 10]),
        .pwm_o(lamp_pwm[g])
      );
    end
  endgenerate

  logic [8:0] pwm_sel;
  always_comb begin
    pwm_sel = {9{pa_q_ff}}; // RULE15
    pwm_sel[5] = pb_q_ff; // RULE15
    pwm_sel[7] = pb_q_ff; // RULE15
    if (pwm_source_select_i) begin
      pwm_sel[7:4] = lamp_pwm; // RULE16 RULE17
    end
  end

  logic [8:0] gate;
  assign gate = out_on_i & (~output_pwm_enable_i | pwm_sel); // RULE13 RULE14 RULE23

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      out_drive_o <= 9'h000;
      out_hiz_o <= 9'h1FF;
    end else if (!drivers_en_o || supply_block) begin
      out_drive_o <= 9'h000; // RULE6
      out_hiz_o <= 9'h1FF;
    end else begin
      out_drive_o <= gate;
      out_hiz_o <= ~gate;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_uv_sets_flags: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE8
    ps_undervolt_i |=> (uv_flag_ff && comb_flag_ff)) else $error("uv flags not set");
  chk_uv_tristate: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE6
    ps_undervolt_i |=> out_hiz_o == 9'h1FF) else $error("outputs not tristated");
  chk_oc_sets_comb: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE7
    overcurrent_i |=> comb_flag_ff) else $error("combined flag missed");
  chk_lock_holds: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE10
    (fault_lock_ff && !status_clear_i) |=> out_drive_o == 9'h000) else $error("lock leaked");
  chk_stby_no_pump: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE12
    (mode_ff == opm_pkg::OPM_STBY) |-> !charge_pump_output_o) else $error("pump on in standby");
  chk_act_min_wait: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1
    $rose(drivers_en_o) |-> $past(mode_ff) == opm_pkg::OPM_WAKE
      && $past(dly_ff) >= 16'(opm_pkg::ACT_DLY_CYC - 1)) else $error("active too early");
  chk_stby_fast: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE2
    (csb_rise && !mode_active_i && drivers_en_o) |=> !drivers_en_o) else $error("standby slow");
  chk_pwm_gate: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE23
    (drivers_en_o && !supply_block && !out_on_i[0]) |=> !out_drive_o[0]) else $error("off drove");
  chk_wake_bounded: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1
    (mode_ff == opm_pkg::OPM_WAKE) |-> dly_ff <= 16'(opm_pkg::ACT_DLY_CYC - 1))
    else $error("wake overran");
  chk_stby_outputs_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE2
    (mode_ff == opm_pkg::OPM_STBY) |=> out_hiz_o == 9'h1FF) else $error("standby drove");
  chk_pwr_up_wait: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE3
    $rose(serial_ready_o) |-> $past(dly_ff) >= 16'(opm_pkg::PWRUP_DLY_CYC - 1))
    else $error("ready too early");
  chk_tw_filter: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE4
    $changed(tw_ff) |-> $past(tw_cnt_ff) == 16'(opm_pkg::FILT_CYC - 1))
    else $error("warning not filtered");
  chk_tsd_filter: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE4
    $changed(tsd_ff) |-> $past(tsd_cnt_ff) == 16'(opm_pkg::FILT_CYC - 1))
    else $error("shutdown not filtered");
  chk_lock_sets: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE10
    ((ps_undervolt_i || ps_overvolt_i) && supply_fault_recovery_bit_i) |=> fault_lock_ff)
    else $error("lock not set");
  chk_lock_frees: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE9
    !supply_fault_recovery_bit_i |=> !fault_lock_ff) else $error("lock kept");
  chk_auto_recover: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE9
    (drivers_en_o && !ps_undervolt_i && !ps_overvolt_i && !fault_lock_ff)
      |=> out_drive_o == $past(gate)) else $error("outputs not restored");
  chk_src_external: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE15
    !pwm_source_select_i |-> pwm_sel[7:4] == {pb_q_ff, pa_q_ff, pb_q_ff, pa_q_ff})
    else $error("lamp pin map wrong");
  chk_bridge_pin_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE15
    (pwm_sel[3:0] == {4{pa_q_ff}}) && (pwm_sel[8] == pa_q_ff)) else $error("bridge pin wrong");
endmodule
`default_nettype wire

// ===== tb/opm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module opm_host_model (
  input wire logic clk_i, // system clock
  output logic csb_o, // chip select, active low
  output logic mode_o // operating-mode bit
);
  // ----------------------------------------
  // idle: chip select released high
  // ----------------------------------------
  initial begin
    csb_o = 1'b1;
    mode_o = 1'b0;
  end

  // ----------------------------------------
  // one frame of 24 link periods of 800 ns; mode bit held past the rising edge
  // ----------------------------------------
  task automatic write_mode(input logic m);
    @(posedge clk_i);
    #1;
    mode_o = m;
    csb_o = 1'b0;
    repeat (24 * 8) @(posedge clk_i);
    #1;
    csb_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/output_pwm_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module output_pwm_mode_control_test;
  logic clk = 1'b0, nrst = 1'b0, sup = 1'b0, csb, mode, src = 1'b0, res = 1'b0, rec = 1'b0;
  logic clr = 1'b0, pa = 1'b0, pb = 1'b0, oc = 1'b0, ov = 1'b0, uv = 1'b0, tw = 1'b0;
  logic ts = 1'b0, rdy, cp, den, cf, uvf, twf, tsf;
  logic [8:0] on = 9'h000, pen = 9'h000, drv, hiz;
  logic [3:0] fsel = 4'h0;
  logic [39:0] duty = 40'h0;
  int fails = 0, checks = 0, n, h0, h1;

  always #50 clk = ~clk;

  opm_host_model opm_host_model_inst (.clk_i(clk), .csb_o(csb), .mode_o(mode));

  opm_ctrl opm_ctrl_inst (
    .clk_i(clk), .nrst_i(nrst), .logic_supply_ok_i(sup), .csb_i(csb), .mode_active_i(mode),
    .out_on_i(on), .output_pwm_enable_i(pen), .pwm_source_select_i(src),
    .pwm_resolution_select_i(res), .pwm_freq_select_i(fsel), .pwm_duty_value_i(duty),
    .supply_fault_recovery_bit_i(rec), .status_clear_i(clr), .pwm_pin_a_i(pa),
    .sense_or_pwm_pin_b_i(pb), .overcurrent_i(oc), .ps_overvolt_i(ov), .ps_undervolt_i(uv),
    .thermal_warn_raw_i(tw), .thermal_sd_raw_i(ts), .serial_ready_o(rdy),
    .charge_pump_output_o(cp), .drivers_en_o(den), .out_drive_o(drv), .out_hiz_o(hiz),
    .combined_fault_status_bit_o(cf), .power_supply_undervolt_flag_o(uvf),
    .thermal_warning_flag_o(twf), .thermal_shutdown_flag_o(tsf)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string what);
    checks++;
    if (v < lo || v > hi) begin
      fails++;
      $display("CHECK FAILED t=%0t %s count %0d not in %0d..%0d", $time, what, v, lo, hi);
    end
  endtask

  // high time of a 16-step pulse at a given frequency
  function automatic int hit(input int f);
    return 16 * opm_pkg::CLK_HZ / (f * 1024);
  endfunction

  task automatic hi_time(input int b, output int h);
    int k;
    k = 0;
    h = 0;
    while (drv[b] !== 1'b0 && k < 70000) begin tick(1); k++; end
    while (drv[b] !== 1'b1 && k < 140000) begin tick(1); k++; end
    while (drv[b] === 1'b1 && h < 70000) begin tick(1); h++; end
  endtask

  task automatic clear_status;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(2);
  endtask

  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #(90000 * 100);
    fails++;
    results();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    tick(5);
    check(hiz, 9'h1FF, "reset hiz");
    nrst = 1'b1;
    tick(5);
    check(rdy, 1'b0, "ready while unpowered");
    sup = 1'b1;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin tick(1); n++; end
    rng(n, 0, 300, "power-up delay");
    check(cp, 1'b0, "pump off in standby");
    opm_host_model_inst.write_mode(1'b1);
    tick(20);
    check(cp, 1'b1, "pump on after wake");
    n = 20;
    while (den !== 1'b1 && n < 5000) begin tick(1); n++; end
    rng(n, 2100, 4000, "wake delay");
    on = 9'h1FF;
    tick(8);
    check(drv, 9'h1FF, "on without pwm");
    pen = 9'h1FF;
    pb = 1'b1;
    tick(2);
    check(drv, 9'h000, "pins not yet synced");
    tick(6);
    check(drv, 9'h0A0, "pin b lamps");
    pa = 1'b1;
    pb = 1'b0;
    tick(8);
    check(drv, 9'h15F, "pin a outputs");
    on = 9'h0F0;
    pb = 1'b1;
    tick(8);
    check(drv, 9'h0F0, "on and pwm");
    check(hiz, 9'h10F, "off outputs tristated");
    on = 9'h1FF;
    src = 1'b1;
    fsel = 4'h2;
    duty = {10'h000, 10'h380, 10'h002, 10'h382};
    tick(8);
    check(drv & 9'h10F, 9'h10F, "bridges keep pin a");
    fork
      hi_time(4, h0);
      hi_time(5, h1);
    join
    rng(h0, hit(200), hit(135), "low frequency pulse");
    rng(h1, hit(260), hit(175), "high frequency pulse");
    check(drv[6], 1'b0, "seven-bit field zero");
    res = 1'b1;
    n = 0;
    while (drv[6] !== 1'b1 && n < 8000) begin tick(1); n++; end
    rng(n, 0, 7999, "ten-bit field used");
    src = 1'b0;
    pen = 9'h000;
    uv = 1'b1;
    tick(3);
    check(hiz, 9'h1FF, "undervoltage hiz");
    check(drv, 9'h000, "undervoltage off");
    check({cf, uvf}, 2'b11, "undervoltage flags");
    uv = 1'b0;
    tick(3);
    check(drv, 9'h1FF, "auto recovery");
    check(cf, 1'b1, "flag sticky");
    clear_status();
    check({cf, uvf}, 2'b00, "flags cleared");
    rec = 1'b1;
    uv = 1'b1;
    tick(3);
    uv = 1'b0;
    tick(20);
    check(hiz, 9'h1FF, "lockout holds");
    clear_status();
    tick(2);
    check(drv, 9'h1FF, "released after clear");
    rec = 1'b0;
    oc = 1'b1;
    tick(3);
    check({cf, uvf}, 2'b10, "overcurrent flag");
    clear_status();
    check({cf, uvf}, 2'b10, "set wins over clear");
    oc = 1'b0;
    clear_status();
    ov = 1'b1;
    tick(3);
    check({cf, uvf}, 2'b10, "overvoltage flag");
    ov = 1'b0;
    clear_status();
    tw = 1'b1;
    ts = 1'b1;
    tick(99);
    check({twf, tsf}, 2'b00, "thermal filtered");
    tick(901);
    check({twf, tsf}, 2'b11, "thermal flags set");
    opm_host_model_inst.write_mode(1'b0);
    n = 0;
    while (den !== 1'b0 && n < 4000) begin tick(1); n++; end
    rng(n, 0, 3000, "standby delay");
    check(cp, 1'b0, "pump off again");
    opm_host_model_inst.write_mode(1'b1);
    tick(10);
    check(cp, 1'b1, "pump on in wake");
    opm_host_model_inst.write_mode(1'b0);
    tick(10);
    check({den, cp}, 2'b00, "wake aborted");
    results();
  end
endmodule
`default_nettype wire
